//--- rtl/ucm_pkg.sv
`default_nettype none
package ucm_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_INTSTAT     = 8'h08;
  localparam logic [7:0]  OFS_INTMASK     = 8'h0C;
  localparam int unsigned CTRL_DETEN      = 0;
  localparam int unsigned CTRL_ADVEN      = 1;
  localparam int unsigned CTRL_ADVMODE    = 2;
  localparam int unsigned CTRL_DEFST      = 4;
  localparam int unsigned CTRL_GP2SEL     = 6;
  localparam int unsigned CTRL_RESTART    = 7;
  localparam int unsigned CTRL_W          = 7;
  localparam logic [6:0]  CTRL_RST        = 7'h00;
  localparam logic [1:0]  DEFST_PIN_EN    = 2'h1;
  localparam int unsigned ST_TYPE         = 0;
  localparam int unsigned ST_BUSY         = 3;
  localparam int unsigned ST_ADV          = 4;
  localparam int unsigned ST_HOST         = 5;
  localparam int unsigned ST_CONF         = 6;
  localparam int unsigned ST_SMI          = 7;
  localparam int unsigned ST_VALID        = 8;
  localparam int unsigned INT_DONE        = 0;
  localparam int unsigned INT_CHANGE      = 1;
  localparam int unsigned INT_VBUS        = 2;
  localparam int unsigned INT_W           = 3;
  localparam logic [2:0]  INT_RST         = 3'h0;
  localparam int unsigned STRAP_CATCH_CYC = 4;
  localparam int unsigned DET_SETTLE_NS   = 2000;
  localparam int unsigned DET_SETTLE_CYC  = (DET_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned VBUS_OFF_US     = 100000;
  localparam int unsigned VBUS_OFF_CYC    = VBUS_OFF_US * CLK_MHZ;
  typedef enum logic [2:0] {
    CHG_NONE, CHG_ACP_HIGH, CHG_ACP_MID, CHG_ACP_LOW, CHG_DCP_12V, CHG_DCP, CHG_CDP
  } ucm_chg_t;
  typedef enum logic [1:0] {ADV_ACP_HIGH, ADV_DCP_12V, ADV_DCP, ADV_CDP} ucm_adv_t;
endpackage
`default_nettype wire

//--- rtl/ucm_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module ucm_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] ff1_r;
  logic [WIDTH-1:0] ff2_r;
  logic [WIDTH-1:0] ff3_r;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
    end else begin
      ff1_r <= asyncIn;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // A bit only moves once the second and third stage agree, which rejects a single-cycle glitch.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          syncOut[i] <= 1'b0;
        end else if (ff2_r[i] == ff3_r[i]) begin
          syncOut[i] <= ff3_r[i];
        end
      end
    end
  endgenerate
endmodule // ucm_sync3
`default_nettype wire

//--- rtl/ucm_charger_ctrl.sv
// Contract
// RULE1: advertise only as host, detect only as peripheral
// RULE2: peripheral detection needs detection enable set
// RULE3: detection yields one of six charger types
// RULE4: host advertises only with advertise enable
// RULE5: advertised mode selectable among four choices
// RULE6: enables from straps, or registers when managed
// RULE7: unconfigured behaviour follows straps or registers
// RULE8: unconfigured advertising requests VBUS power cycle
// RULE9: default field one: pin enables detection
// RULE10: indicator pin shows detect or interrupt
// RULE11: detected type latched until next detection
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ucm_charger_ctrl #(
  parameter int unsigned VBUS_OFF_CYC = ucm_pkg::VBUS_OFF_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        smiModeIn,
  input  wire logic        roleHost,
  input  wire logic        roleConfigured,
  input  wire logic        strapDetEn,
  input  wire logic        strapAdvEn,
  input  wire logic [1:0]  strapAdvMode,
  input  wire logic [1:0]  cmpAcpClass,
  input  wire logic        cmpDcp12Short,
  input  wire logic        cmpDcpShort,
  input  wire logic        cmpCdp,
  input  wire logic        detectEnablePinIn,
  output var  logic        advOn,
  output var  logic [1:0]  advModeOut,
  output var  logic        detectRun,
  output var  logic        vbusCycleRequestPinOut,
  output var  logic        vbusCycleRequestPinOe,
  output var  logic        interruptOrDetectIndicatorPinOut,
  output var  logic        interruptOrDetectIndicatorPinOe,
  output var  logic        irq
);
  localparam int unsigned DCW = $clog2(ucm_pkg::DET_SETTLE_CYC + 1);
  localparam int unsigned VCW = $clog2(VBUS_OFF_CYC + 1);
  localparam logic [DCW-1:0] DET_LAST = DCW'(ucm_pkg::DET_SETTLE_CYC - 1);
  localparam logic [VCW-1:0] VBUS_LOAD = VCW'(VBUS_OFF_CYC);

  typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_DONE, S_ADV} ucm_state_t;

  // One-hot register select, shared by the read path and the write path.
  function automatic logic [3:0] regSel(input logic [7:0] a);
    regSel[0] = (a == ucm_pkg::OFS_CTRL);
    regSel[1] = (a == ucm_pkg::OFS_STATUS);
    regSel[2] = (a == ucm_pkg::OFS_INTSTAT);
    regSel[3] = (a == ucm_pkg::OFS_INTMASK);
  endfunction

  // Fixed priority: proprietary classes first, then the shorted ports, then a charging downstream port.
  function automatic ucm_pkg::ucm_chg_t classify(input logic [1:0] acp, input logic d12, input logic dcp,
                                                 input logic cdp);
    if (acp == 2'h3) classify = ucm_pkg::CHG_ACP_HIGH;
    else if (acp == 2'h2) classify = ucm_pkg::CHG_ACP_MID;
    else if (acp == 2'h1) classify = ucm_pkg::CHG_ACP_LOW;
    else if (d12) classify = ucm_pkg::CHG_DCP_12V;
    else if (dcp) classify = ucm_pkg::CHG_DCP;
    else if (cdp) classify = ucm_pkg::CHG_CDP;
    else classify = ucm_pkg::CHG_NONE;
  endfunction

  // Everything from pins and analog comparators crosses into mclk here.
  logic [10:0] syncBits;
  ucm_sync3 #(.WIDTH(11)) u_sync (
    .mclk    (mclk),
    .rstn    (rstn),
    .asyncIn ({smiModeIn, strapDetEn, strapAdvEn, strapAdvMode, cmpAcpClass, cmpDcp12Short,
               cmpDcpShort, cmpCdp, detectEnablePinIn}),
    .syncOut (syncBits)
  );
  wire       smiMode   = syncBits[10];
  wire       sDetEn    = syncBits[9];
  wire       sAdvEn    = syncBits[8];
  wire [1:0] sAdvMode  = syncBits[7:6];
  wire [1:0] sAcp      = syncBits[5:4];
  wire       sDcp12    = syncBits[3];
  wire       sDcp      = syncBits[2];
  wire       sCdp      = syncBits[1];
  wire       sPinDetEn = syncBits[0];

  localparam int unsigned CTRL_W_L = ucm_pkg::CTRL_W;
  logic [CTRL_W_L-1:0] ctrl_r;
  logic [2:0]          intStat_r;
  logic [2:0]          intStat_nxt;
  logic [2:0]          intMask_r;
  logic                wrPend_r;
  logic [7:0]          wrAddr_r;
  logic [2:0]          strapCnt_r;
  logic                strapDone_r;
  logic                strapDetEn_r;
  logic                strapAdvEn_r;
  logic [1:0]          strapAdvMode_r;
  ucm_state_t          state_r;
  ucm_state_t          state_nxt;
  logic [DCW-1:0]      detCnt_r;
  logic [DCW-1:0]      detCnt_nxt;
  logic [VCW-1:0]      vbusCnt_r;
  logic [VCW-1:0]      vbusCnt_nxt;
  ucm_pkg::ucm_chg_t   chgType_r;
  logic                chgValid_r;

  // Bus decode.
  wire       addrPhase = hsel & htrans[1] & hready;
  wire [3:0] rdSel     = regSel(haddr[7:0]);
  wire [3:0] wrSel     = regSel(wrAddr_r);
  wire       ctrlWr    = wrPend_r & wrSel[0];
  wire       maskWr    = wrPend_r & wrSel[3];
  wire       statRd    = addrPhase & ~hwrite & rdSel[2];
  wire       restartReq = ctrlWr & hwdata[ucm_pkg::CTRL_RESTART];

  // Control sources: registers when the management interface is in use, straps otherwise.
  wire       cDetEn    = ctrl_r[ucm_pkg::CTRL_DETEN];
  wire       cAdvEn    = ctrl_r[ucm_pkg::CTRL_ADVEN];
  wire [1:0] cAdvMode  = ctrl_r[ucm_pkg::CTRL_ADVMODE +: 2];
  wire [1:0] cDefSt    = ctrl_r[ucm_pkg::CTRL_DEFST +: 2];
  wire       cGp2Sel   = ctrl_r[ucm_pkg::CTRL_GP2SEL];
  wire       detEnEff  = smiMode ? cDetEn : strapDetEn_r;                        // [RULE6]
  wire       advEnEff  = smiMode ? cAdvEn : strapAdvEn_r;                        // [RULE6]
  wire [1:0] advModeEff = smiMode ? cAdvMode : strapAdvMode_r;                   // [RULE5]
  wire       pinGate   = smiMode & (cDefSt == ucm_pkg::DEFST_PIN_EN);           // [RULE9]
  wire       unconfDet = pinGate ? sPinDetEn : (detEnEff & ~advEnEff);          // [RULE7] [RULE9]
  // Nothing runs until the straps have been caught, so strap mode never acts on reset values.
  wire       wantDet   = strapDone_r & (roleConfigured ? (~roleHost & detEnEff) : unconfDet); // [RULE1] [RULE2]
  wire       wantAdv   = strapDone_r & (roleConfigured ? (roleHost & advEnEff) : advEnEff);   // [RULE1] [RULE4]
  wire       settleEnd = (state_r == S_SETTLE) & (detCnt_r == DET_LAST);
  wire       advStart  = (state_r == S_IDLE) & wantAdv;
  wire       vbusStart = advStart & ~roleConfigured;                             // [RULE8]

  ucm_pkg::ucm_chg_t newType;
  assign newType = classify(sAcp, sDcp12, sDcp, sCdp);                           // [RULE3]

  wire [2:0] intEv;
  assign intEv[ucm_pkg::INT_DONE]   = settleEnd;
  assign intEv[ucm_pkg::INT_CHANGE] = settleEnd & (newType != chgType_r);
  assign intEv[ucm_pkg::INT_VBUS]   = vbusStart;
  // A read clears the status; an event in the same cycle survives it.
  assign intStat_nxt = (intStat_r & ~(statRd ? 3'h7 : 3'h0)) | intEv;

  wire [31:0] statusWord = {23'h000000, chgValid_r, smiMode, roleConfigured, roleHost,
                            (state_r == S_ADV), (state_r == S_SETTLE), chgType_r};
  wire [31:0] rdMux = rdSel[0] ? {25'h0000000, ctrl_r} :
                      rdSel[1] ? statusWord :
                      rdSel[2] ? {29'h00000000, intStat_r} :
                      rdSel[3] ? {29'h00000000, intMask_r} : 32'h00000000;

  always_comb begin
    state_nxt   = state_r;
    detCnt_nxt  = detCnt_r;
    vbusCnt_nxt = (vbusCnt_r != '0) ? vbusCnt_r - VCW'(1) : vbusCnt_r;
    case (state_r)
      S_IDLE: begin
        if (wantAdv) begin
          state_nxt = S_ADV;
          if (vbusStart) begin
            vbusCnt_nxt = VBUS_LOAD;                                             // [RULE8]
          end
        end else if (wantDet) begin
          state_nxt  = S_SETTLE;
          detCnt_nxt = '0;
        end
      end
      S_SETTLE: begin
        if (!wantDet) begin
          state_nxt = S_IDLE;
        end else if (settleEnd) begin
          state_nxt = S_DONE;
        end else begin
          detCnt_nxt = detCnt_r + DCW'(1);
        end
      end
      S_DONE: begin
        if (!wantDet) begin
          state_nxt = S_IDLE;
        end else if (restartReq) begin
          state_nxt  = S_SETTLE;
          detCnt_nxt = '0;
        end
      end
      S_ADV: begin
        if (!wantAdv) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // AHB-Lite slave with no wait states: the read word is loaded at the address phase edge.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wrPend_r  <= 1'b0;
      wrAddr_r  <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_r  <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_r <= haddr[7:0];
      end
      if (addrPhase & ~hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_r    <= ucm_pkg::CTRL_RST;
      intMask_r <= ucm_pkg::INT_RST;
      intStat_r <= ucm_pkg::INT_RST;
    end else begin
      intStat_r <= intStat_nxt;
      if (ctrlWr) begin
        ctrl_r <= hwdata[CTRL_W_L-1:0];
      end
      if (maskWr) begin
        intMask_r <= hwdata[2:0];
      end
    end
  end

  // Straps are caught once, a few cycles after reset release, when the synchroniser has settled.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      strapCnt_r     <= 3'h0;
      strapDone_r    <= 1'b0;
      strapDetEn_r   <= 1'b0;
      strapAdvEn_r   <= 1'b0;
      strapAdvMode_r <= 2'h0;
    end else if (!strapDone_r) begin
      strapCnt_r <= strapCnt_r + 3'h1;
      if (strapCnt_r == 3'(ucm_pkg::STRAP_CATCH_CYC)) begin
        strapDone_r    <= 1'b1;
        strapDetEn_r   <= sDetEn;                                                // [RULE6] [RULE7]
        strapAdvEn_r   <= sAdvEn;
        strapAdvMode_r <= sAdvMode;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r    <= S_IDLE;
      detCnt_r   <= '0;
      vbusCnt_r  <= '0;
      chgType_r  <= ucm_pkg::CHG_NONE;
      chgValid_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      detCnt_r  <= detCnt_nxt;
      vbusCnt_r <= vbusCnt_nxt;
      if (settleEnd) begin
        chgType_r  <= newType;                                                   // [RULE11]
        chgValid_r <= 1'b1;
      end
    end
  end

  // advOn, detectRun, the VBUS request and the interrupt are registered from next-state values so they line up with the state they describe.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      advOn                            <= 1'b0;
      advModeOut                       <= 2'h0;
      detectRun                        <= 1'b0;
      vbusCycleRequestPinOut           <= 1'b0;
      vbusCycleRequestPinOe            <= 1'b0;
      interruptOrDetectIndicatorPinOut <= 1'b0;
      interruptOrDetectIndicatorPinOe  <= 1'b0;
      irq                              <= 1'b0;
    end else begin
      advOn                            <= (state_nxt == S_ADV);                  // [RULE1] [RULE4]
      advModeOut                       <= advModeEff;                            // [RULE5]
      detectRun                        <= (state_nxt == S_SETTLE);               // [RULE2]
      // Open drain: the request pulls the pin low for the power-off time.
      vbusCycleRequestPinOut           <= 1'b0;
      vbusCycleRequestPinOe            <= (vbusCnt_nxt != '0);                   // [RULE8]
      interruptOrDetectIndicatorPinOut <= cGp2Sel ? (chgValid_r & (chgType_r != ucm_pkg::CHG_NONE)) :
                                                    (|(intStat_nxt & intMask_r)); // [RULE10]
      interruptOrDetectIndicatorPinOe  <= 1'b1;
      irq                              <= |(intStat_nxt & intMask_r);
    end
  end
endmodule // ucm_charger_ctrl
`default_nettype wire

//--- sim/ucm_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ucm_checker #(
  parameter int unsigned VBUS_OFF_CYC = 20
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        roleHost,
  input wire logic        roleConfigured,
  input wire logic        advOn,
  input wire logic        detectRun,
  input wire logic        vbusCycleRequestPinOut,
  input wire logic        vbusCycleRequestPinOe,
  input wire logic        interruptOrDetectIndicatorPinOe
);
  localparam int unsigned SETTLE = ucm_pkg::DET_SETTLE_CYC;
  logic [31:0] oeCnt_r;
  logic [31:0] detCnt_r;
  always_ff @(posedge mclk) begin
    oeCnt_r  <= (rstn && vbusCycleRequestPinOe) ? oeCnt_r + 32'h1 : 32'h0;
    detCnt_r <= (rstn && detectRun) ? detCnt_r + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  read_hold_a: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  host_no_det_a: assert property ($past(roleConfigured && roleHost) |-> !$rose(detectRun))
    else $error("detection started in host role");
  peri_no_adv_a: assert property ($past(roleConfigured && !roleHost) |-> !advOn)
    else $error("advertising in peripheral role");
  adv_det_excl_a: assert property (!(advOn && detectRun)) else $error("advertise and detect together");
  settle_len_a: assert property (detectRun |-> detCnt_r <= SETTLE) else $error("detection settle too long");
  vbus_len_a: assert property ($fell(vbusCycleRequestPinOe) |-> oeCnt_r == VBUS_OFF_CYC)
    else $error("vbus request length wrong");
  vbus_cause_a: assert property ($rose(vbusCycleRequestPinOe) |-> advOn && !$past(roleConfigured))
    else $error("vbus request without unconfigured advertising");
  vbus_od_a: assert property (vbusCycleRequestPinOut == 1'b0) else $error("vbus request pin driven high");
  ind_oe_a: assert property ($past(rstn) |-> interruptOrDetectIndicatorPinOe)
    else $error("indicator pin not driven");
endmodule // ucm_checker
bind ucm_charger_ctrl ucm_checker #(.VBUS_OFF_CYC(VBUS_OFF_CYC)) i_chk (.mclk(mclk), .rstn(rstn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .roleHost(roleHost), .roleConfigured(roleConfigured), .advOn(advOn), .detectRun(detectRun),
  .vbusCycleRequestPinOut(vbusCycleRequestPinOut), .vbusCycleRequestPinOe(vbusCycleRequestPinOe),
  .interruptOrDetectIndicatorPinOe(interruptOrDetectIndicatorPinOe));
`default_nettype wire

//--- sim/ucm_charger_model.sv
`timescale 1ns/100ps
`default_nettype none
module ucm_charger_model (
  input  wire logic [2:0] chgType,
  input  wire logic       vbusCycleRequestPinOe,
  output var  logic [1:0] cmpAcpClass,
  output var  logic       cmpDcp12Short,
  output var  logic       cmpDcpShort,
  output var  logic       cmpCdp,
  output var  logic       vbusPresent
);
  always_comb begin
    cmpAcpClass   = 2'h0;
    cmpDcp12Short = 1'b0;
    cmpDcpShort   = 1'b0;
    cmpCdp        = 1'b0;
    case (chgType)
      ucm_pkg::CHG_ACP_HIGH: cmpAcpClass = 2'h3;
      ucm_pkg::CHG_ACP_MID:  cmpAcpClass = 2'h2;
      ucm_pkg::CHG_ACP_LOW:  cmpAcpClass = 2'h1;
      ucm_pkg::CHG_DCP_12V:  cmpDcp12Short = 1'b1;
      ucm_pkg::CHG_DCP:      cmpDcpShort = 1'b1;
      ucm_pkg::CHG_CDP:      cmpCdp = 1'b1;
      default: ;
    endcase
  end
  // The request line is open drain with a pull-up; the system drops VBUS while it is held low.
  assign vbusPresent = !vbusCycleRequestPinOe;
endmodule // ucm_charger_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        mclk, rstn, hsel, hwrite, hreadyout, hresp, smiModeIn, roleHost, roleConfigured;
  logic        strapDetEn, strapAdvEn, cmpDcp12Short, cmpDcpShort, cmpCdp, detectEnablePinIn;
  logic        advOn, detectRun, vbusOut, vbusOe, indOut, indOe, irq, vbusPresent, sawRun, sawOff;
  logic [1:0]  htrans, strapAdvMode, cmpAcpClass, advModeOut;
  logic [2:0]  hsize, chgType, ty;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          err_count, samples_checked;
  ucm_charger_ctrl #(.VBUS_OFF_CYC(20)) i_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .smiModeIn(smiModeIn), .roleHost(roleHost),
    .roleConfigured(roleConfigured), .strapDetEn(strapDetEn), .strapAdvEn(strapAdvEn),
    .strapAdvMode(strapAdvMode), .cmpAcpClass(cmpAcpClass), .cmpDcp12Short(cmpDcp12Short),
    .cmpDcpShort(cmpDcpShort), .cmpCdp(cmpCdp), .detectEnablePinIn(detectEnablePinIn), .advOn(advOn),
    .advModeOut(advModeOut), .detectRun(detectRun), .vbusCycleRequestPinOut(vbusOut),
    .vbusCycleRequestPinOe(vbusOe), .interruptOrDetectIndicatorPinOut(indOut),
    .interruptOrDetectIndicatorPinOe(indOe), .irq(irq));
  ucm_charger_model i_model (.chgType(chgType), .vbusCycleRequestPinOe(vbusOe), .cmpAcpClass(cmpAcpClass),
    .cmpDcp12Short(cmpDcp12Short), .cmpDcpShort(cmpDcpShort), .cmpCdp(cmpCdp), .vbusPresent(vbusPresent));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (!vbusPresent) sawOff <= 1'b1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr; hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Bounded wait that also tells whether a detection ran at all.
  task automatic waitDet();
    sawRun = 1'b0;
    for (int n = 0; n < 400 && !(sawRun && detectRun === 1'b0); n++) begin
      tick(1);
      if (detectRun === 1'b1) sawRun = 1'b1;
    end
  endtask
  task automatic doReset();
    rstn <= 1'b0;
    tick(8);
    rstn <= 1'b1;
    tick(8);
  endtask
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    {rstn, hsel, hwrite, strapDetEn, strapAdvEn, roleHost, detectEnablePinIn, sawOff} = '0;
    {htrans, strapAdvMode, hsize, chgType, haddr, hwdata} = '0;
    smiModeIn = 1'b1;
    roleConfigured = 1'b1;
    doReset();
    busXfer(1'b1, 8'h10, 32'hFFFFFFFF);
    busXfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    busXfer(1'b0, ucm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      ty = 3'(i + 1);
      chgType <= ty;
      busXfer(1'b1, ucm_pkg::OFS_INTMASK, (i == 5) ? 32'h0 : 32'h3);
      busXfer(1'b1, ucm_pkg::OFS_CTRL, (i == 0) ? 32'h1 : 32'h81);
      waitDet();
      chk({31'h0, sawRun}, 32'h1);
      busXfer(1'b0, ucm_pkg::OFS_STATUS, 32'h0);
      chk(rd & 32'h107, {23'h0, 1'b1, 5'h0, ty});
      tick(1);
      chk({31'h0, irq}, (i == 5) ? 32'h0 : 32'h1);
      chk({31'h0, indOut}, (i == 5) ? 32'h0 : 32'h1);
      busXfer(1'b0, ucm_pkg::OFS_INTSTAT, 32'h0);
      chk(rd, 32'h3);
      tick(2);
      chk({31'h0, irq}, 32'h0);
    end
    busXfer(1'b1, ucm_pkg::OFS_CTRL, 32'h40);
    tick(2);
    chk({31'h0, indOut}, 32'h1);
    busXfer(1'b1, ucm_pkg::OFS_CTRL, 32'h80);
    waitDet();
    chk({31'h0, sawRun}, 32'h0);
    roleHost <= 1'b1;
    busXfer(1'b1, ucm_pkg::OFS_CTRL, 32'h81);
    waitDet();
    chk({31'h0, sawRun}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      busXfer(1'b1, ucm_pkg::OFS_CTRL, 32'h2 | (m << 2));
      tick(8);
      chk({30'h0, advOn, vbusOe}, 32'h2);
      chk({30'h0, advModeOut}, 32'(m));
    end
    busXfer(1'b1, ucm_pkg::OFS_CTRL, 32'h0);
    tick(8);
    chk({31'h0, advOn}, 32'h0);
    roleConfigured <= 1'b0;
    busXfer(1'b1, ucm_pkg::OFS_CTRL, 32'hA);
    tick(40);
    chk({30'h0, advOn, sawOff}, 32'h3);
    busXfer(1'b0, ucm_pkg::OFS_INTSTAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    detectEnablePinIn <= 1'b1;
    busXfer(1'b1, ucm_pkg::OFS_CTRL, 32'h90);
    waitDet();
    chk({31'h0, sawRun}, 32'h1);
    smiModeIn <= 1'b0;
    strapAdvEn <= 1'b1;
    strapAdvMode <= 2'h2;
    doReset();
    tick(40);
    chk({29'h0, advOn, advModeOut}, 32'h6);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
